/* File: hdl/tqp_consts.vh */
`ifndef TQP_CONSTS_VH
`define TQP_CONSTS_VH

// register bus
`define TQP_ADDR_W 8
`define TQP_REG_W 16
`define TQP_CH_INVALID 2'h3
`define TQP_ADDR_TOP 7
`define TQP_CH_SEL 6:5
`define TQP_IDX_SEL 4:2
`define TQP_RESP_OKAY 2'h0
`define TQP_RESP_SLVERR 2'h2

// register index within a channel, byte offset = channel * 32 + index * 4
`define TQP_IDX_CTRL 3'h0
`define TQP_IDX_IOC 3'h1
`define TQP_IDX_IEN 3'h2
`define TQP_IDX_STAT 3'h3
`define TQP_IDX_CNT 3'h4
`define TQP_IDX_CMPA 3'h5
`define TQP_IDX_CMPB 3'h6
`define TQP_IDX_LAST 3'h6

// timer_control_reg fields
`define TQP_CTRL_MODE 1:0
`define TQP_CTRL_QSUB 3:2
`define TQP_CTRL_PSC 6:4
`define TQP_CTRL_PSC_EXT 5:4
`define TQP_CTRL_EDGE 8:7
`define TQP_CTRL_CLR 10:9
`define TQP_CTRL_SYNC 11
`define TQP_CTRL_RUN 15

// io_control_reg fields
`define TQP_IOC_A_ACT 1:0
`define TQP_IOC_A_CAP 2
`define TQP_IOC_B_ACT 4:3
`define TQP_IOC_B_CAP 5
`define TQP_IOC_A_INIT 6
`define TQP_IOC_B_INIT 7

// interrupt_enable_reg fields
`define TQP_IEN_W 4

// status_reg fields
`define TQP_STAT_PAD_HI 8'h00
`define TQP_STAT_PAD_LO 3'h0

// modes
`define TQP_MODE_NORMAL 2'h0
`define TQP_MODE_PWM1 2'h1
`define TQP_MODE_PWM2 2'h2
`define TQP_MODE_QUAD 2'h3

// quadrature sub-modes 1 to 4
`define TQP_QSUB_1 2'h0
`define TQP_QSUB_2 2'h1
`define TQP_QSUB_3 2'h2
`define TQP_QSUB_4 2'h3

// counter clear select
`define TQP_CLR_NONE 2'h0
`define TQP_CLR_A 2'h1
`define TQP_CLR_B 2'h2
`define TQP_CLR_SYNC 2'h3

// output action on match, also capture edge when capture is on
`define TQP_ACT_NONE 2'h0
`define TQP_ACT_LOW 2'h1
`define TQP_ACT_HIGH 2'h2
`define TQP_ACT_TOGGLE 2'h3
`define TQP_CAP_RISE 2'h1
`define TQP_CAP_FALL 2'h2
`define TQP_CAP_BOTH 2'h3

// clock prescale select
`define TQP_PSC_DIV1 3'h0
`define TQP_PSC_DIV4 3'h1
`define TQP_PSC_DIV16 3'h2
`define TQP_PSC_DIV64 3'h3
`define TQP_PSC_EXT_A 3'h4
`define TQP_PSC_EXT_B 3'h5
`define TQP_PSC_EXT_C 3'h6
`define TQP_PSC_EXT_D 3'h7
`define TQP_PRE_W 6
`define TQP_PRE_M4 6'h03
`define TQP_PRE_M16 6'h0f
`define TQP_PRE_M64 6'h3f

// clock edge select
`define TQP_EDGE_RISE 2'h0
`define TQP_EDGE_FALL 2'h1

// values
`define TQP_CNT_MAX 16'hffff
`define TQP_CNT_ZERO 16'h0000
`define TQP_CNT_ONE 16'h0001
`define TQP_REG_RST 16'h0000

`endif

/* File: hdl/tqp_qdec.v */
`timescale 1ns/1ps
`include "tqp_consts.vh"
module tqp_qdec (
  input wire [1:0] sub_mode,
  input wire pa,
  input wire pb,
  input wire pa_rise,
  input wire pa_fall,
  input wire pb_rise,
  input wire pb_fall,
  output reg up,
  output reg down
);
  // phase a leading phase b counts up
  always @* begin
    up = 1'b0;
    down = 1'b0;
    case (sub_mode)
      `TQP_QSUB_1: begin
        up = (pa & pb_rise) | (~pa & pb_fall) | (pa_rise & ~pb) | (pa_fall & pb);
        down = (pa & pb_fall) | (~pa & pb_rise) | (pa_rise & pb) | (pa_fall & ~pb);
      end
      `TQP_QSUB_2: begin
        up = pa_fall & pb;
        down = pa_fall & ~pb;
      end
      `TQP_QSUB_3: begin
        up = pa_fall & pb;
        down = pb_fall & pa;
      end
      default: begin
        up = (pa & pb_rise) | (~pa & pb_fall);
        down = (pa & pb_fall) | (~pa & pb_rise);
      end
    endcase
  end
endmodule

/* File: hdl/tqp_sync.v */
`timescale 1ns/1ps
module tqp_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  // three stages, output follows once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule

/* File: hdl/tqp_timer.v */
`timescale 1ns/1ps
`include "tqp_consts.vh"
module tqp_timer (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire ext_clock_input_a,
  input wire ext_clock_input_b,
  input wire ext_clock_input_c,
  input wire ext_clock_input_d,
  input wire [2:0] io_pin_a_in,
  output wire [2:0] io_pin_a_out,
  output wire [2:0] io_pin_a_oe,
  input wire [2:0] io_pin_b_in,
  output wire [2:0] io_pin_b_out,
  output wire [2:0] io_pin_b_oe,
  output wire [2:0] int_request
);
  // input synchronisation and edges
  wire [9:0] sy;
  reg [9:0] sy_prev;
  wire [9:0] sy_rise;
  wire [9:0] sy_fall;
  wire [3:0] ext_lvl;
  wire [3:0] ext_rise;
  wire [3:0] ext_fall;

  tqp_sync #(.W(10)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({io_pin_b_in, io_pin_a_in, ext_clock_input_d, ext_clock_input_c,
      ext_clock_input_b, ext_clock_input_a}),
    .dout(sy)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      sy_prev <= 10'h000;
    end else begin
      sy_prev <= sy;
    end
  end

  assign sy_rise = sy & ~sy_prev;
  assign sy_fall = ~sy & sy_prev;
  assign ext_lvl = sy[3:0];
  assign ext_rise = sy_rise[3:0];
  assign ext_fall = sy_fall[3:0];

  // shared prescaler
  reg [`TQP_PRE_W-1:0] pre;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre <= {`TQP_PRE_W{1'b0}};
    end else begin
      pre <= pre + `TQP_PRE_M4 - `TQP_PRE_M4 + {{(`TQP_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // write channel
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire [7:0] wr_addr;
  wire [15:0] wr_data;
  wire [1:0] wr_strb;
  wire [2:0] wr_idx;
  wire [1:0] wr_ch;
  reg wr_ok;
  wire [2:0] wr_hit;

  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign wr_fire = (aw_held | aw_take) & (w_held | w_take);
  assign wr_addr = aw_held ? aw_addr_q : awaddr;
  assign wr_data = w_held ? w_data_q[15:0] : wdata[15:0];
  assign wr_strb = w_held ? w_strb_q[1:0] : wstrb[1:0];
  assign wr_idx = wr_addr[`TQP_IDX_SEL];
  assign wr_ch = wr_addr[`TQP_CH_SEL];

  always @* begin
    if (wr_addr[`TQP_ADDR_TOP]) begin
      wr_ok = 1'b0;
    end else if (wr_ch == `TQP_CH_INVALID) begin
      wr_ok = 1'b0;
    end else if (wr_idx > `TQP_IDX_LAST) begin
      wr_ok = 1'b0;
    end else begin
      wr_ok = 1'b1;
    end
  end

  assign wr_hit = (wr_fire & wr_ok) ? (3'h1 << wr_ch) : 3'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TQP_RESP_OKAY;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b1;
      bresp <= wr_ok ? `TQP_RESP_OKAY : `TQP_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel
  wire [2:0] rd_idx;
  wire [1:0] rd_ch;
  wire [47:0] ch_rd;
  reg rd_ok;

  assign arready = ~rvalid;
  assign rd_idx = araddr[`TQP_IDX_SEL];
  assign rd_ch = araddr[`TQP_CH_SEL];

  always @* begin
    if (araddr[`TQP_ADDR_TOP]) begin
      rd_ok = 1'b0;
    end else if (rd_ch == `TQP_CH_INVALID) begin
      rd_ok = 1'b0;
    end else if (rd_idx > `TQP_IDX_LAST) begin
      rd_ok = 1'b0;
    end else begin
      rd_ok = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TQP_RESP_OKAY;
    end else if (arvalid & arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? {16'h0000, ch_rd[{rd_ch, 4'h0} +: 16]} : 32'h00000000;
      rresp <= rd_ok ? `TQP_RESP_OKAY : `TQP_RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
    end
  end

  // cross-channel clearing
  wire [2:0] own_clear;
  wire [2:0] sync_en;
  wire sync_clear;
  assign sync_clear = |(own_clear & sync_en);

  function [15:0] wmerge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] strb;
    begin
      wmerge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  function act_level;
    input lvl;
    input [1:0] code;
    begin
      case (code)
        `TQP_ACT_LOW: act_level = 1'b0;
        `TQP_ACT_HIGH: act_level = 1'b1;
        `TQP_ACT_TOGGLE: act_level = ~lvl;
        default: act_level = lvl;
      endcase
    end
  endfunction

  function cap_edge;
    input rise;
    input fall;
    input [1:0] code;
    begin
      cap_edge = ((code == `TQP_CAP_RISE) & rise) | ((code == `TQP_CAP_FALL) & fall) |
        ((code == `TQP_CAP_BOTH) & (rise | fall));
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      localparam QUAD_OK = (g != 0);
      localparam PA = (g == 2) ? 2 : 0;
      reg [15:0] ctrl;
      reg [15:0] ioc;
      reg [15:0] ien;
      reg [15:0] cnt;
      reg [15:0] cmpa;
      reg [15:0] cmpb;
      reg fa;
      reg fb;
      reg fov;
      reg fun;
      reg dir;
      reg lvl_a;
      reg lvl_b;
      reg tick;
      reg [15:0] rdv;
      wire [1:0] mode;
      wire [1:0] csel;
      wire quad;
      wire run;
      wire q_up;
      wire q_dn;
      wire up;
      wire dn;
      wire a_cap;
      wire b_cap;
      wire a_match;
      wire b_match;
      wire a_capev;
      wire b_capev;
      wire clr;
      wire eq_hold;
      wire [15:0] cyc_val;
      wire cyc_own;
      wire [15:0] ov_clr;

      assign mode = ctrl[`TQP_CTRL_MODE];
      assign csel = ctrl[`TQP_CTRL_CLR];
      assign run = ctrl[`TQP_CTRL_RUN];
      assign quad = QUAD_OK && (mode == `TQP_MODE_QUAD);
      assign sync_en[g] = ctrl[`TQP_CTRL_SYNC];

      tqp_qdec u_qdec (
        .sub_mode(ctrl[`TQP_CTRL_QSUB]),
        .pa(ext_lvl[PA]),
        .pb(ext_lvl[PA+1]),
        .pa_rise(ext_rise[PA]),
        .pa_fall(ext_fall[PA]),
        .pb_rise(ext_rise[PA+1]),
        .pb_fall(ext_fall[PA+1]),
        .up(q_up),
        .down(q_dn)
      );

      always @* begin
        tick = 1'b0;
        case (ctrl[`TQP_CTRL_PSC])
          `TQP_PSC_DIV1: tick = 1'b1;
          `TQP_PSC_DIV4: tick = (pre & `TQP_PRE_M4) == `TQP_PRE_M4;
          `TQP_PSC_DIV16: tick = (pre & `TQP_PRE_M16) == `TQP_PRE_M16;
          `TQP_PSC_DIV64: tick = (pre & `TQP_PRE_M64) == `TQP_PRE_M64;
          default: begin
            if (ctrl[`TQP_CTRL_EDGE] == `TQP_EDGE_RISE) begin
              tick = ext_rise[ctrl[`TQP_CTRL_PSC_EXT]];
            end else if (ctrl[`TQP_CTRL_EDGE] == `TQP_EDGE_FALL) begin
              tick = ext_fall[ctrl[`TQP_CTRL_PSC_EXT]];
            end else begin
              tick = ext_rise[ctrl[`TQP_CTRL_PSC_EXT]] | ext_fall[ctrl[`TQP_CTRL_PSC_EXT]];
            end
          end
        endcase
      end

      assign up = run & (quad ? q_up : tick);
      assign dn = run & quad & q_dn;

      // compare, capture and clear stay live in every mode
      assign a_cap = ioc[`TQP_IOC_A_CAP];
      assign b_cap = ioc[`TQP_IOC_B_CAP];
      assign a_match = ~a_cap & (up | dn) & (cnt == cmpa);
      assign b_match = ~b_cap & (up | dn) & (cnt == cmpb);
      assign a_capev = a_cap & cap_edge(sy_rise[4+g], sy_fall[4+g], ioc[`TQP_IOC_A_ACT]);
      assign b_capev = b_cap & cap_edge(sy_rise[7+g], sy_fall[7+g], ioc[`TQP_IOC_B_ACT]);
      assign own_clear[g] = ((csel == `TQP_CLR_A) & a_match) |
        ((csel == `TQP_CLR_B) & b_match);
      assign clr = own_clear[g] |
        (run & (csel == `TQP_CLR_SYNC) & sync_en[g] & sync_clear);
      assign eq_hold = (cmpa == cmpb);
      // only a channel clearing on its own match has a local cycle register
      assign cyc_own = (csel == `TQP_CLR_A) | (csel == `TQP_CLR_B);
      assign cyc_val = (csel == `TQP_CLR_A) ? cmpa : cmpb;
      assign ov_clr = wmerge(`TQP_REG_RST, wr_data, wr_strb);

      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl <= `TQP_REG_RST;
          ioc <= `TQP_REG_RST;
          ien <= `TQP_REG_RST;
          cnt <= `TQP_CNT_ZERO;
          cmpa <= `TQP_CNT_MAX;
          cmpb <= `TQP_CNT_MAX;
          fa <= 1'b0;
          fb <= 1'b0;
          fov <= 1'b0;
          fun <= 1'b0;
          dir <= 1'b1;
          lvl_a <= 1'b0;
          lvl_b <= 1'b0;
        end else begin
          if (wr_hit[g] && wr_idx == `TQP_IDX_CTRL) ctrl <= wmerge(ctrl, wr_data, wr_strb);
          if (wr_hit[g] && wr_idx == `TQP_IDX_IOC) ioc <= wmerge(ioc, wr_data, wr_strb);
          if (wr_hit[g] && wr_idx == `TQP_IDX_IEN) ien <= wmerge(ien, wr_data, wr_strb);
          // counter: software write, clear, up, down
          if (wr_hit[g] && wr_idx == `TQP_IDX_CNT) begin
            cnt <= wmerge(cnt, wr_data, wr_strb);
          end else if (clr) begin
            cnt <= `TQP_CNT_ZERO;
          end else if (up) begin
            cnt <= cnt + `TQP_CNT_ONE;
          end else if (dn) begin
            cnt <= cnt - `TQP_CNT_ONE;
          end
          // capture wins over a software write
          if (a_capev) begin
            cmpa <= cnt;
          end else if (wr_hit[g] && wr_idx == `TQP_IDX_CMPA) begin
            cmpa <= wmerge(cmpa, wr_data, wr_strb);
          end
          if (b_capev) begin
            cmpb <= cnt;
          end else if (wr_hit[g] && wr_idx == `TQP_IDX_CMPB) begin
            cmpb <= wmerge(cmpb, wr_data, wr_strb);
          end
          // sticky flags, write one clears, a new event wins
          fa <= (fa & ~(wr_hit[g] && wr_idx == `TQP_IDX_STAT && ov_clr[0])) | a_match | a_capev;
          fb <= (fb & ~(wr_hit[g] && wr_idx == `TQP_IDX_STAT && ov_clr[1])) | b_match | b_capev;
          fov <= (fov & ~(wr_hit[g] && wr_idx == `TQP_IDX_STAT && ov_clr[2])) |
            (up & ~clr & (cnt == `TQP_CNT_MAX));
          fun <= (fun & ~(wr_hit[g] && wr_idx == `TQP_IDX_STAT && ov_clr[3])) |
            (dn & ~clr & (cnt == `TQP_CNT_ZERO));
          if (up) begin
            dir <= 1'b1;
          end else if (dn) begin
            dir <= 1'b0;
          end
          // pin levels
          if (!run) begin
            lvl_a <= ioc[`TQP_IOC_A_INIT];
            lvl_b <= ioc[`TQP_IOC_B_INIT];
          end else if (mode == `TQP_MODE_PWM1) begin
            if (eq_hold) begin
              lvl_a <= lvl_a;
            end else if (a_match) begin
              lvl_a <= act_level(lvl_a, ioc[`TQP_IOC_A_ACT]);
            end else if (b_match) begin
              lvl_a <= act_level(lvl_a, ioc[`TQP_IOC_B_ACT]);
            end
          end else if (mode == `TQP_MODE_PWM2 && clr) begin
            lvl_a <= ioc[`TQP_IOC_A_INIT];
            lvl_b <= ioc[`TQP_IOC_B_INIT];
          end else begin
            if (a_match && !(mode == `TQP_MODE_PWM2 && cyc_own && cmpa == cyc_val)) begin
              lvl_a <= act_level(lvl_a, ioc[`TQP_IOC_A_ACT]);
            end
            if (b_match && !(mode == `TQP_MODE_PWM2 && cyc_own && cmpb == cyc_val)) begin
              lvl_b <= act_level(lvl_b, ioc[`TQP_IOC_B_ACT]);
            end
          end
        end
      end

      // pwm mode 2 drives no pin for the own cycle register
      assign io_pin_a_out[g] = lvl_a;
      assign io_pin_b_out[g] = lvl_b;
      assign io_pin_a_oe[g] = ~a_cap & ((mode == `TQP_MODE_PWM1) |
        ((mode == `TQP_MODE_PWM2) & (csel != `TQP_CLR_A)) |
        ((mode != `TQP_MODE_PWM1) & (mode != `TQP_MODE_PWM2) &
        (ioc[`TQP_IOC_A_ACT] != `TQP_ACT_NONE)));
      assign io_pin_b_oe[g] = ~b_cap & (((mode == `TQP_MODE_PWM2) & (csel != `TQP_CLR_B)) |
        ((mode != `TQP_MODE_PWM1) & (mode != `TQP_MODE_PWM2) &
        (ioc[`TQP_IOC_B_ACT] != `TQP_ACT_NONE)));
      assign int_request[g] = |({fun, fov, fb, fa} & ien[`TQP_IEN_W-1:0]);

      always @* begin
        if (rd_idx == `TQP_IDX_CTRL) begin
          rdv = ctrl;
        end else if (rd_idx == `TQP_IDX_IOC) begin
          rdv = ioc;
        end else if (rd_idx == `TQP_IDX_IEN) begin
          rdv = ien;
        end else if (rd_idx == `TQP_IDX_STAT) begin
          rdv = {`TQP_STAT_PAD_HI, dir, `TQP_STAT_PAD_LO, fun, fov, fb, fa};
        end else if (rd_idx == `TQP_IDX_CNT) begin
          rdv = cnt;
        end else if (rd_idx == `TQP_IDX_CMPA) begin
          rdv = cmpa;
        end else begin
          rdv = cmpb;
        end
      end
      assign ch_rd[g*16 +: 16] = rdv;
    end
  endgenerate
endmodule

/* File: sim/tqp_encoder.sv */
`timescale 1ns/1ps
// two-phase encoder, phase a leads b when moving forward
module tqp_encoder (
  input wire aclk,
  output logic pa,
  output logic pb
);
  initial begin
    pa = 1'b0;
    pb = 1'b0;
  end
  // one full cycle, four edges eight clocks apart
  task automatic cycle(input bit fwd);
    for (int i = 0; i < 4; i++) begin
      repeat (8) @(posedge aclk);
      if (fwd == i[0]) pb <= ~pb;
      else pa <= ~pa;
    end
  endtask
endmodule

/* File: sim/tqp_timer_assertions.sv */
`timescale 1ns/1ps
// bus handshake checks on the top ports
module tqp_timer_assertions (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  sequence rd_bad;
    arvalid && arready && araddr[7];
  endsequence

  wr_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rd_resp_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  wr_answer_a: assert property (wr_both |=> bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |=> rvalid)
    else $error("read response late");
  rd_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  bad_read_a: assert property (rd_bad |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
endmodule

bind tqp_timer tqp_timer_assertions i_tqp_timer_assertions (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready);

/* File: sim/tqp_timer_test.sv */
`timescale 1ns/1ps
module tqp_timer_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire pa1, pb1, pa2, pb2;
  wire [2:0] pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, int_request;
  int n_errors = 0, comparisons = 0;
  int fq[4] = '{4, 1, 1, 2};
  int dv[4] = '{3, 9, 3, 12};
  int hv[4] = '{12, 20, 20, 0};
  logic [15:0] io[4] = '{16'h0011, 16'h0051, 16'h0012, 16'h0051};
  logic [7:0] bad[3] = '{8'h80, 8'h60, 8'h1c};
  logic [2:0] cap_pin = 3'h0;
  int hi;
  int pw[3];

  always #12.5 aclk = ~aclk;

  tqp_timer i_tqp_timer (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ext_clock_input_a(pa1), .ext_clock_input_b(pb1),
    .ext_clock_input_c(pa2), .ext_clock_input_d(pb2), .io_pin_a_in(cap_pin),
    .io_pin_a_out(pin_a_out), .io_pin_a_oe(pin_a_oe), .io_pin_b_in(3'h0),
    .io_pin_b_out(pin_b_out), .io_pin_b_oe(pin_b_oe), .int_request);
  tqp_encoder i_tqp_encoder_ab (.aclk, .pa(pa1), .pb(pb1));
  tqp_encoder i_tqp_encoder_cd (.aclk, .pa(pa2), .pb(pb2));

  function automatic logic [7:0] ad(input int ch, input int idx);
    return {1'b0, ch[1:0], idx[2:0], 2'b00};
  endfunction

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({rresp, rdata & m}, {er, e});
  endtask

  task automatic step(input int ch, input bit fwd);
    if (ch == 1) i_tqp_encoder_ab.cycle(fwd);
    else i_tqp_encoder_cd.cycle(fwd);
    repeat (8) @(posedge aclk);
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and refused addresses
    rd(ad(1, 0), 32'hffff, 32'h0, 2'h0);
    rd(ad(1, 5), 32'hffff, 32'hffff, 2'h0);
    rd(ad(1, 3), 32'h8c, 32'h80, 2'h0);
    foreach (bad[k]) rd(bad[k], 32'hffffffff, 32'h0, 2'h2);
    // stopped timer shows the start level
    wr(ad(0, 1), 16'h0040);
    repeat (2) @(posedge aclk);
    chk(pin_a_out[0], 1'b1);
    // pwm mode 1, period 10 ticks, two periods sampled
    foreach (dv[k]) begin
      wr(ad(0, 5), 16'd9);
      wr(ad(0, 6), dv[k][15:0]);
      wr(ad(0, 1), io[k]);
      wr(ad(0, 0), 16'h8201);
      repeat (25) @(posedge aclk);
      hi = 0;
      repeat (20) begin
        @(posedge aclk);
        if (pin_a_out[0] === 1'b1) hi++;
      end
      chk(hi, hv[k]);
      chk({pin_a_oe[0], pin_b_oe[0]}, 2'b10);
      wr(ad(0, 0), 16'h0000);
    end
    // quadrature sub-modes on both channels, prescale and edge set to ignored values
    for (int ch = 1; ch < 3; ch++) begin
      for (int s = 0; s < 4; s++) begin
        wr(ad(ch, 0), 16'h80b3 | {12'h0, s[1:0], 2'b00});
        wr(ad(ch, 2), 16'h000c);
        wr(ad(ch, 4), 16'hffff);
        step(ch, 1'b1);
        rd(ad(ch, 4), 32'hffff, 32'(fq[s] - 1), 2'h0);
        rd(ad(ch, 3), 32'h8c, 32'h84, 2'h0);
        chk(int_request[ch], 1'b1);
        wr(ad(ch, 3), 16'h000f);
        step(ch, 1'b0);
        rd(ad(ch, 4), 32'hffff, 32'hffff, 2'h0);
        rd(ad(ch, 3), 32'h8c, 32'h08, 2'h0);
        wr(ad(ch, 3), 16'h000f);
      end
      wr(ad(ch, 0), 16'h0000);
    end
    // channel 0 ignores quadrature mode and counts phase a rises
    wr(ad(0, 4), 16'h0000);
    wr(ad(0, 0), 16'h8043);
    step(1, 1'b1);
    rd(ad(0, 4), 32'hffff, 32'h1, 2'h0);
    // capture keeps working in quadrature mode
    wr(ad(1, 1), 16'h0005);
    wr(ad(1, 0), 16'h8003);
    wr(ad(1, 4), 16'h1234);
    cap_pin <= 3'h2;
    repeat (8) @(posedge aclk);
    rd(ad(1, 5), 32'hffff, 32'h1234, 2'h0);
    // pwm mode 2, channel 1 b sets the cycle, synced channel 0 follows
    wr(ad(1, 1), 16'h0012);
    wr(ad(0, 1), 16'h0012);
    wr(ad(1, 4), 16'h0000);
    wr(ad(1, 5), 16'h0003);
    wr(ad(1, 6), 16'h0009);
    wr(ad(0, 5), 16'h0005);
    wr(ad(0, 6), 16'h0007);
    wr(ad(0, 0), 16'h8e02);
    wr(ad(1, 0), 16'h8c02);
    repeat (25) @(posedge aclk);
    pw = '{0, 0, 0};
    repeat (20) begin
      @(posedge aclk);
      if (pin_a_out[1] === 1'b1) pw[0]++;
      if (pin_a_out[0] === 1'b1) pw[1]++;
      if (pin_b_out[0] === 1'b1) pw[2]++;
    end
    chk(pw[0], 12);
    chk(pw[1], 8);
    chk(pw[2], 4);
    chk({pin_a_oe[1], pin_b_oe[1], pin_a_oe[0], pin_b_oe[0]}, 4'b1011);
    report_and_stop;
  end
endmodule
